// ==== rtl/sdms_select.sv ====
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
module sdms_select
   import sdms_pkg::*;
#(
   parameter int DW = DATA_W
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [RD_W-1:0] reg_wr_data,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [RD_W-1:0] reg_rd_data,
   input wire logic speed_position_switch,
   input wire logic speed_torque_switch,
   input wire logic torque_position_switch,
   input wire logic position_command_trigger,
   input wire logic [2:0] position_select_inputs,
   input wire logic [1:0] speed_select_inputs,
   input wire logic [1:0] torque_select_inputs,
   input wire logic signed [DW-1:0] analog_speed,
   input wire logic signed [DW-1:0] analog_torque,
   input wire logic pulse_step,
   input wire logic pulse_dir,
   output sdms_state_e active_mode,
   output logic motor_hold,
   output logic position_valid,
   output logic signed [DW-1:0] position_cmd,
   output logic signed [DW-1:0] speed_cmd,
   output logic signed [DW-1:0] torque_cmd,
   output logic speed_limit_active,
   output logic signed [DW-1:0] speed_limit,
   output logic torque_limit_active,
   output logic signed [DW-1:0] torque_limit
);

   function automatic logic signed [DW-1:0] cmd_pick(
      input logic [1:0] sel,
      input logic signed [DW-1:0] ana,
      input logic signed [DW-1:0] p0,
      input logic signed [DW-1:0] p1,
      input logic signed [DW-1:0] p2);
      // Dual modes never offer the zero-command variant
      case (sel) // [RULE2] [RULE22] [RULE23]
         2'h1: cmd_pick = p0;
         2'h2: cmd_pick = p1;
         2'h3: cmd_pick = p2;
         default: cmd_pick = ana;
      endcase
   endfunction

   function automatic logic signed [DW-1:0] cap(
      input logic signed [DW-1:0] v,
      input logic [DW-2:0] m);
      logic signed [DW-1:0] top;
      top = $signed({1'b0, m});
      if (v > top) begin
         cap = top;
      end else if (v < -top) begin
         cap = -top;
      end else begin
         cap = v;
      end
   endfunction

   logic [7:0] mode_r;
   logic [1:0] lim_en_r;
   logic signed [DW-1:0] spd_par_r [3];
   logic signed [DW-1:0] trq_par_r [3];
   logic signed [DW-1:0] pos_par_r [NUM_POS];
   logic [DW-2:0] max_speed_r;
   logic sp_r, st_r, tp_r, trig_r, trig_d_r;
   sdms_state_e state_r, state_nxt, other_state;
   logic signed [DW-1:0] pulse_cnt_r;
   logic signed [DW-1:0] pos_latch_r;
   logic signed [DW-1:0] position_cmd_r, speed_cmd_r, torque_cmd_r;
   logic signed [DW-1:0] speed_limit_r, torque_limit_r;
   logic [RD_W-1:0] rd_data_r, rd_mux;

   wire is_ps = (mode_r == MODE_PT_S) || (mode_r == MODE_PR_S);
   wire is_pt = (mode_r == MODE_PT_T) || (mode_r == MODE_PR_T);
   wire is_st = (mode_r == MODE_S_T);
   wire mode_ok = is_ps || is_pt || is_st; // [RULE1]
   wire pulse_mode = (mode_r == MODE_PT_S) || (mode_r == MODE_PT_T);
   wire reg_pos = (mode_r == MODE_PR_S) || (mode_r == MODE_PR_T);
   wire trig_rise = trig_r && !trig_d_r; // [RULE24]
   wire pos_req = (is_ps && !sp_r) || (is_pt && tp_r); // [RULE5] [RULE13]
   wire trq_req = (is_pt && !tp_r) || (is_st && st_r); // [RULE10] [RULE14]
   wire count_en = (state_r == ST_POS_RUN) && pulse_mode; // [RULE14]
   wire signed [DW-1:0] spd_sel = cmd_pick(speed_select_inputs,
      analog_speed, spd_par_r[0], spd_par_r[1], spd_par_r[2]); // [RULE8]
   wire signed [DW-1:0] trq_sel = cmd_pick(torque_select_inputs,
      analog_torque, trq_par_r[0], trq_par_r[1], trq_par_r[2]); // [RULE9]
   wire signed [DW-1:0] pos_pick = pos_par_r[position_select_inputs];
   wire spd_lim_on = lim_en_r[LIM_SPD_BIT] && (state_r == ST_TORQUE);
   wire trq_lim_on = lim_en_r[LIM_TRQ_BIT] &&
      ((state_r == ST_SPEED) || (state_r == ST_POS_RUN) ||
       (state_r == ST_POS_WAIT));
   wire wr_mode = reg_wr && (reg_addr == ADR_MODE);
   wire wr_lim = reg_wr && (reg_addr == ADR_LIMIT_EN);
   wire wr_max = reg_wr && (reg_addr == ADR_MAX_SPEED);
   wire wr_spd = reg_wr && (reg_addr >= ADR_SPD_PAR) &&
      (reg_addr < ADR_TRQ_PAR);
   wire wr_trq = reg_wr && (reg_addr >= ADR_TRQ_PAR) &&
      (reg_addr < ADR_POS_PAR);
   wire wr_pos = reg_wr && (reg_addr >= ADR_POS_PAR) &&
      (reg_addr < ADR_MAX_SPEED);
   wire [ADDR_W-1:0] spd_idx = reg_addr - ADR_SPD_PAR;
   wire [ADDR_W-1:0] trq_idx = reg_addr - ADR_TRQ_PAR;
   wire [ADDR_W-1:0] pos_idx = reg_addr - ADR_POS_PAR;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         mode_r <= RST_MODE;
         lim_en_r <= 2'h0;
         max_speed_r <= RST_MAX_SPEED;
         spd_par_r <= '{default: '0};
         trq_par_r <= '{default: '0};
         pos_par_r <= '{default: '0};
      end else begin
         if (wr_mode) mode_r <= reg_wr_data[7:0];
         if (wr_lim) lim_en_r <= reg_wr_data[1:0];
         if (wr_max) max_speed_r <= reg_wr_data[DW-2:0];
         if (wr_spd) spd_par_r[spd_idx[1:0]] <= reg_wr_data[DW-1:0];
         if (wr_trq) trq_par_r[trq_idx[1:0]] <= reg_wr_data[DW-1:0];
         if (wr_pos) pos_par_r[pos_idx[2:0]] <= reg_wr_data[DW-1:0];
      end
   end

   // Inputs are synchronous already; one stage gives a clean edge compare
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sp_r <= 1'b0;
         st_r <= 1'b0;
         tp_r <= 1'b0;
         trig_r <= 1'b0;
         trig_d_r <= 1'b0;
      end else begin
         sp_r <= speed_position_switch; // [RULE24]
         st_r <= speed_torque_switch; // [RULE24]
         tp_r <= torque_position_switch; // [RULE24]
         trig_r <= position_command_trigger; // [RULE24]
         trig_d_r <= trig_r; // [RULE24]
      end
   end

   assign other_state = !mode_ok ? ST_IDLE :
      (trq_req ? ST_TORQUE : ST_SPEED); // [RULE7] [RULE11] [RULE12]

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_POS_WAIT: begin
            if (!pos_req) begin
               state_nxt = other_state; // [RULE7]
            end else if (trig_rise || !is_ps) begin
               // Torque/position entry never waits for a trigger
               state_nxt = ST_POS_RUN; // [RULE6] [RULE15]
            end
         end
         ST_POS_RUN: begin
            if (!pos_req) begin
               state_nxt = other_state; // [RULE7] [RULE14]
            end
         end
         default: begin
            // Speed/position entry waits for a trigger; others run at once
            if (pos_req) begin
               state_nxt = is_ps ? ST_POS_WAIT : ST_POS_RUN; // [RULE5] [RULE15]
            end else begin
               state_nxt = other_state; // [RULE4] [RULE10] [RULE11]
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Counting stops outside position run even with pulses arriving
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pulse_cnt_r <= '0;
      end else if (count_en && pulse_step) begin
         pulse_cnt_r <= pulse_dir ? pulse_cnt_r - 1'b1 :
            pulse_cnt_r + 1'b1; // [RULE3] [RULE13]
      end
   end

   // A trigger seen while the switch leaves the wait is ignored
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pos_latch_r <= '0;
      end else if ((state_r == ST_POS_WAIT) && pos_req && trig_rise) begin
         pos_latch_r <= reg_pos ? pos_pick : pulse_cnt_r; // [RULE3] [RULE6]
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         position_cmd_r <= '0;
         speed_cmd_r <= '0;
         torque_cmd_r <= '0;
         speed_limit_r <= '0;
         torque_limit_r <= TRQ_FULL;
      end else begin
         position_cmd_r <= reg_pos ? pos_latch_r : pulse_cnt_r; // [RULE3]
         speed_cmd_r <= (state_r == ST_SPEED) ?
            cap(spd_sel, max_speed_r) : '0; // [RULE11] [RULE16]
         torque_cmd_r <= (state_r == ST_TORQUE) ? trq_sel : '0; // [RULE10]
         speed_limit_r <= spd_lim_on ? cap(spd_sel, max_speed_r) :
            $signed({1'b0, max_speed_r}); // [RULE16] [RULE17] [RULE18]
         torque_limit_r <= trq_lim_on ? trq_sel : TRQ_FULL; // [RULE19] [RULE20]
      end
   end

   always_comb begin
      rd_mux = '0;
      if (reg_addr == ADR_MODE) begin
         rd_mux[7:0] = mode_r;
      end else if (reg_addr == ADR_LIMIT_EN) begin
         rd_mux[1:0] = lim_en_r;
      end else if (reg_addr == ADR_MAX_SPEED) begin
         rd_mux[DW-2:0] = max_speed_r;
      end else if (reg_addr == ADR_STATUS) begin
         rd_mux[4:0] = state_r;
         rd_mux[STAT_VALID_BIT] = (state_r == ST_POS_RUN);
         rd_mux[STAT_BAD_BIT] = !mode_ok;
      end else if (reg_addr == ADR_PULSE_CNT) begin
         rd_mux[DW-1:0] = pulse_cnt_r;
      end else if (wr_spd || (reg_addr >= ADR_SPD_PAR &&
                   reg_addr < ADR_TRQ_PAR)) begin
         rd_mux[DW-1:0] = spd_par_r[spd_idx[1:0]];
      end else if (reg_addr >= ADR_TRQ_PAR && reg_addr < ADR_POS_PAR) begin
         rd_mux[DW-1:0] = trq_par_r[trq_idx[1:0]];
      end else if (reg_addr >= ADR_POS_PAR && reg_addr < ADR_MAX_SPEED) begin
         rd_mux[DW-1:0] = pos_par_r[pos_idx[2:0]];
      end
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rd_data_r <= '0;
      end else begin
         rd_data_r <= reg_rd ? rd_mux : '0;
      end
   end

   assign reg_rd_data = rd_data_r;
   assign active_mode = state_r;
   assign motor_hold = (state_r == ST_POS_WAIT) || (state_r == ST_IDLE);
   assign position_valid = (state_r == ST_POS_RUN);
   assign position_cmd = position_cmd_r;
   assign speed_cmd = speed_cmd_r;
   assign torque_cmd = torque_cmd_r;
   assign speed_limit_active = spd_lim_on;
   assign speed_limit = speed_limit_r;
   assign torque_limit_active = trq_lim_on;
   assign torque_limit = torque_limit_r;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   sequence s_sp_fall;
      is_ps && sp_r ##1 is_ps && !sp_r && !trig_rise;
   endsequence

   sequence s_trig_take;
      state_r == ST_POS_WAIT && pos_req && trig_rise && reg_pos;
   endsequence

   a_speed_ignores_trig: assert property ( // [RULE4]
      state_r == ST_SPEED |=> $stable(pos_latch_r))
      else $error("Trigger changed latch in speed mode");

   a_sp_enter_wait: assert property ( // [RULE5]
      s_sp_fall |=> state_r == ST_POS_WAIT && motor_hold)
      else $error("Switch off did not enter held wait");

   a_wait_holds: assert property ( // [RULE5]
      is_ps && state_r == ST_POS_WAIT && pos_req && !trig_rise
      |=> state_r == ST_POS_WAIT)
      else $error("Left wait without a trigger");

   a_trig_latch_pos: assert property ( // [RULE6]
      s_trig_take |=> state_r == ST_POS_RUN &&
      pos_latch_r == $past(pos_pick) ##1 position_cmd_r == $past(pos_latch_r))
      else $error("Trigger did not latch selected position");

   a_sp_back_speed: assert property ( // [RULE7]
      is_ps && sp_r |=> state_r == ST_SPEED)
      else $error("Switch on did not return to speed");

   a_st_select: assert property ( // [RULE10] [RULE11] [RULE12]
      is_st |=> state_r == ($past(st_r) ? ST_TORQUE : ST_SPEED))
      else $error("Speed torque switch ignored");

   a_tp_select: assert property ( // [RULE13] [RULE14] [RULE15]
      is_pt |=> state_r == ($past(tp_r) ? ST_POS_RUN : ST_TORQUE))
      else $error("Torque position switch ignored");

   a_count_gate: assert property ( // [RULE14]
      !count_en |=> $stable(pulse_cnt_r))
      else $error("Pulses counted while gated");

   a_speed_cap: assert property ( // [RULE16]
      1'b1 |=> speed_cmd_r <= $signed({1'b0, $past(max_speed_r)}) &&
      speed_cmd_r >= -$signed({1'b0, $past(max_speed_r)}))
      else $error("Speed command above maximum");

   a_spd_lim_gate: assert property ( // [RULE17] [RULE18]
      speed_limit_active |-> state_r == ST_TORQUE && lim_en_r[LIM_SPD_BIT])
      else $error("Speed limit active out of torque mode");

   a_trq_lim_gate: assert property ( // [RULE19] [RULE20]
      !lim_en_r[LIM_TRQ_BIT] || state_r == ST_TORQUE
      |=> torque_limit_r == TRQ_FULL)
      else $error("Torque limit applied while disabled");

   a_trq_cmd_zero: assert property ( // [RULE10] [RULE14]
      state_r != ST_TORQUE |=> torque_cmd_r == '0)
      else $error("Torque command outside torque mode");

   a_trq_lim_take: assert property ( // [RULE19] [RULE20]
      torque_limit_active |=> torque_limit_r == $past(trq_sel))
      else $error("Torque limit not taken from selection");

   a_spd_lim_off: assert property ( // [RULE16] [RULE18]
      !speed_limit_active |=>
      speed_limit_r == $signed({1'b0, $past(max_speed_r)}))
      else $error("Inactive speed limit not at maximum");

   a_pulse_step: assert property ( // [RULE13]
      count_en && pulse_step |=> pulse_cnt_r == ($past(pulse_dir) ?
      $past(pulse_cnt_r) - 1'b1 : $past(pulse_cnt_r) + 1'b1))
      else $error("Pulse not counted once");

   a_rd_data_clear: assert property (
      !reg_rd |=> reg_rd_data == '0)
      else $error("Read data stood past its cycle");

endmodule // sdms_select

// ==== rtl/sdms_pkg.sv ====
// Summary of operation
// [RULE1] Dual-mode codes 06 to 10, input selects mode
// [RULE2] No dual mode with zero-command variants
// [RULE3] Position from pulses or internal position bank
// [RULE4] Speed/position switch on: speed mode, ignore trigger
// [RULE5] Switch off: position mode, hold until trigger
// [RULE6] Trigger rise latches selected position, then move
// [RULE7] Speed/position switch on again: speed at once
// [RULE8] Speed command: analog or three internal values
// [RULE9] Torque command: analog or three internal values
// [RULE10] Speed/torque switch on: torque mode
// [RULE11] Speed/torque switch off: speed mode, follow now
// [RULE12] Speed/torque switch on again: torque at once
// [RULE13] Torque/position switch on: count and follow pulses
// [RULE14] Switch off: stop counting, torque mode
// [RULE15] Torque/position switch on again: position at once
// [RULE16] Cap speed at maximum in every mode
// [RULE17] Speed limit only in torque mode, speed sources
// [RULE18] Speed limit active only when enable is 1
// [RULE19] Torque limit only in position and speed modes
// [RULE20] Torque limit and its selects need enable 1
// [RULE21] Controller prefers analog and pulse command inputs
// [RULE22] Nonzero torque select picks internal value
// [RULE23] Select input off reads 0, on reads 1
// [RULE24] Register switches and trigger, edge by compare
package sdms_pkg;
   localparam int DATA_W = 16;
   localparam int ADDR_W = 5;
   localparam int RD_W = 32;
   localparam int NUM_POS = 8;
   localparam logic [7:0] MODE_PT_S = 8'h06;
   localparam logic [7:0] MODE_PT_T = 8'h07;
   localparam logic [7:0] MODE_PR_S = 8'h08;
   localparam logic [7:0] MODE_PR_T = 8'h09;
   localparam logic [7:0] MODE_S_T = 8'h0a;
   localparam logic [7:0] RST_MODE = 8'h06;
   localparam logic [ADDR_W-1:0] ADR_MODE = 5'h00;
   localparam logic [ADDR_W-1:0] ADR_LIMIT_EN = 5'h01;
   localparam logic [ADDR_W-1:0] ADR_SPD_PAR = 5'h02;
   localparam logic [ADDR_W-1:0] ADR_TRQ_PAR = 5'h05;
   localparam logic [ADDR_W-1:0] ADR_POS_PAR = 5'h08;
   localparam logic [ADDR_W-1:0] ADR_MAX_SPEED = 5'h10;
   localparam logic [ADDR_W-1:0] ADR_STATUS = 5'h11;
   localparam logic [ADDR_W-1:0] ADR_PULSE_CNT = 5'h12;
   localparam int LIM_SPD_BIT = 0;
   localparam int LIM_TRQ_BIT = 1;
   localparam int STAT_VALID_BIT = 5;
   localparam int STAT_BAD_BIT = 6;
   localparam logic [DATA_W-2:0] RST_MAX_SPEED = 15'h7fff;
   localparam logic [DATA_W-1:0] TRQ_FULL = 16'h7fff;
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_SPEED = 5'h02,
      ST_TORQUE = 5'h04,
      ST_POS_WAIT = 5'h08,
      ST_POS_RUN = 5'h10
   } sdms_state_e;
endpackage

// ==== verification/sdms_ctrl_model.sv ====
`timescale 1ns/1ps
module sdms_ctrl_model
   import sdms_pkg::*;
#(
   parameter logic signed [DATA_W-1:0] ANA_SPD = 16'h0123,
   parameter logic signed [DATA_W-1:0] ANA_TRQ = 16'h0456
) (
   input wire logic clk_sys,
   output logic speed_position_switch,
   output logic speed_torque_switch,
   output logic torque_position_switch,
   output logic position_command_trigger,
   output logic [2:0] position_select_inputs,
   output logic [1:0] speed_select_inputs,
   output logic [1:0] torque_select_inputs,
   output logic signed [DATA_W-1:0] analog_speed,
   output logic signed [DATA_W-1:0] analog_torque,
   output logic pulse_step,
   output logic pulse_dir
);
   // Analog levels carry speed and torque, pulses carry position
   assign analog_speed = ANA_SPD;
   assign analog_torque = ANA_TRQ;
   initial begin
      {speed_position_switch, speed_torque_switch} = 2'h0;
      {torque_position_switch, position_command_trigger} = 2'h0;
      position_select_inputs = 3'h0;
      {speed_select_inputs, torque_select_inputs} = 4'h0;
      {pulse_step, pulse_dir} = 2'h0;
   end
   // Levels change just after an edge, off is 0 and on is 1
   task automatic set_in(input logic sp, st, tp, tg, input logic [2:0] ps,
                         input logic [1:0] ss, ts);
      @(posedge clk_sys);
      speed_position_switch <= sp;
      speed_torque_switch <= st;
      torque_position_switch <= tp;
      position_command_trigger <= tg;
      position_select_inputs <= ps;
      speed_select_inputs <= ss;
      torque_select_inputs <= ts;
   endtask
   // Gaps between pulses keep each one a distinct step
   task automatic send_pulses(input int n, input logic dn);
      for (int i = 0; i < n; i++) begin
         @(posedge clk_sys);
         pulse_step <= 1'b1;
         pulse_dir <= dn;
         @(posedge clk_sys);
         pulse_step <= 1'b0;
      end
   endtask
endmodule // sdms_ctrl_model

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
module testbench;
   import sdms_pkg::*;
   localparam logic signed [DATA_W-1:0] A_SPD = 16'h0123;
   localparam logic signed [DATA_W-1:0] A_TRQ = 16'h0456;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [RD_W-1:0] reg_wr_data = '0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [RD_W-1:0] reg_rd_data, rdv, cnt0;
   logic sp_sw, st_sw, tp_sw, trig, pstep, pdir, hold, pvalid, s_act, t_act;
   logic [2:0] pos_sel;
   logic [1:0] spd_sel, trq_sel;
   logic signed [DATA_W-1:0] a_spd, a_trq, p_cmd, s_cmd, t_cmd, s_lim, t_lim;
   sdms_state_e mode;
   int miscompares = 0;
   int n_checks = 0;
   initial begin
      forever #2 clk_sys = ~clk_sys;
   end
   sdms_ctrl_model #(.ANA_SPD(A_SPD), .ANA_TRQ(A_TRQ)) i_ctrl (
      .clk_sys(clk_sys), .speed_position_switch(sp_sw),
      .speed_torque_switch(st_sw), .torque_position_switch(tp_sw),
      .position_command_trigger(trig), .position_select_inputs(pos_sel),
      .speed_select_inputs(spd_sel), .torque_select_inputs(trq_sel),
      .analog_speed(a_spd), .analog_torque(a_trq),
      .pulse_step(pstep), .pulse_dir(pdir));
   sdms_select i_dut (
      .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wr_data(reg_wr_data), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rd_data(reg_rd_data), .speed_position_switch(sp_sw),
      .speed_torque_switch(st_sw), .torque_position_switch(tp_sw),
      .position_command_trigger(trig), .position_select_inputs(pos_sel),
      .speed_select_inputs(spd_sel), .torque_select_inputs(trq_sel),
      .analog_speed(a_spd), .analog_torque(a_trq), .pulse_step(pstep),
      .pulse_dir(pdir), .active_mode(mode), .motor_hold(hold),
      .position_valid(pvalid), .position_cmd(p_cmd), .speed_cmd(s_cmd),
      .torque_cmd(t_cmd), .speed_limit_active(s_act), .speed_limit(s_lim),
      .torque_limit_active(t_act), .torque_limit(t_lim));
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      n_checks++;
      if (e !== g) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_bit(input string nm, input logic e, g);
      chk(nm, {31'h0, e}, {31'h0, g});
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [RD_W-1:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wr_data <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [RD_W-1:0] q);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      q = reg_rd_data;
   endtask
   // Input sample, state update, then command update
   task automatic set(input logic sp, st, tp, tg, input logic [2:0] ps,
                      input logic [1:0] ss, ts);
      i_ctrl.set_in(sp, st, tp, tg, ps, ss, ts);
      step(3);
   endtask
   function automatic logic [31:0] sx(input logic signed [DATA_W-1:0] v);
      return {{(32-DATA_W){v[DATA_W-1]}}, v};
   endfunction
   initial begin
      repeat (20000) @(posedge clk_sys);
      miscompares++;
      report_and_stop();
   end
   initial begin
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      step(3);
      rd(ADR_MODE, rdv);
      chk("mode_reset", 32'h06, rdv);
      rd(ADR_LIMIT_EN, rdv);
      chk("limit_reset", 32'h0, rdv);
      rd(ADR_MAX_SPEED, rdv);
      chk("max_reset", 32'h7fff, rdv);
      wr(5'h1f, 32'h5a5a);
      rd(5'h1f, rdv);
      chk("unmapped", 32'h0, rdv);
      chk("state_reset", 32'(ST_POS_WAIT), 32'(mode));
      chk_bit("hold_reset", 1'b1, hold);
      wr(ADR_STATUS, 32'hffff);
      rd(ADR_STATUS, rdv);
      chk("status_ro", 32'h08, rdv);
      // Every dual code is accepted and kept
      for (int c = 6; c <= 10; c++) begin
         wr(ADR_MODE, 32'(c));
         rd(ADR_MODE, rdv);
         chk("mode_code", 32'(c), rdv);
         rd(ADR_STATUS, rdv);
         chk_bit("code_ok", 1'b0, rdv[STAT_BAD_BIT]);
      end
      for (int i = 0; i < 3; i++) begin
         wr(ADR_SPD_PAR + 5'(i), 32'(16'h0100 * (i + 1)));
         wr(ADR_TRQ_PAR + 5'(i), 32'(16'h0011 * (i + 1)));
      end
      for (int i = 0; i < NUM_POS; i++)
         wr(ADR_POS_PAR + 5'(i), 32'(16'h1000 + i));
      wr(ADR_MODE, 32'(MODE_PR_S));
      wr(ADR_LIMIT_EN, 32'h2);
      for (int s = 0; s < 4; s++) begin
         set(1'b1, 1'b0, 1'b0, 1'b1, 3'h0, 2'(s), 2'(s));
         chk("spd_state", 32'(ST_SPEED), 32'(mode));
         chk("spd_cmd", s == 0 ? sx(A_SPD) : 32'(s * 256),
            sx(s_cmd));
         chk("trq_lim", s == 0 ? sx(A_TRQ) : 32'(s * 17),
            sx(t_lim));
         chk_bit("tlim_on", 1'b1, t_act);
      end
      // Trigger already high at the switch gives no rising edge
      set(1'b0, 1'b0, 1'b0, 1'b1, 3'h5, 2'h1, 2'h1);
      chk("pos_wait", 32'(ST_POS_WAIT), 32'(mode));
      chk_bit("pos_hold", 1'b1, hold);
      set(1'b0, 1'b0, 1'b0, 1'b0, 3'h5, 2'h1, 2'h1);
      set(1'b0, 1'b0, 1'b0, 1'b1, 3'h5, 2'h1, 2'h1);
      chk("pos_run", 32'(ST_POS_RUN), 32'(mode));
      chk("pos_cmd", 32'h1005, sx(p_cmd));
      chk_bit("pos_valid", 1'b1, pvalid);
      chk_bit("tlim_pos", 1'b1, t_act);
      set(1'b0, 1'b0, 1'b0, 1'b1, 3'h2, 2'h1, 2'h1);
      chk("pos_hold_cmd", 32'h1005, sx(p_cmd));
      set(1'b1, 1'b0, 1'b0, 1'b1, 3'h2, 2'h1, 2'h1);
      chk("spd_back", 32'(ST_SPEED), 32'(mode));
      wr(ADR_LIMIT_EN, 32'h0);
      step(3);
      chk_bit("tlim_off", 1'b0, t_act);
      chk("tlim_full", 32'(TRQ_FULL), sx(t_lim));
      wr(ADR_MAX_SPEED, 32'h0150);
      set(1'b1, 1'b0, 1'b0, 1'b0, 3'h0, 2'h2, 2'h0);
      chk("spd_cap", 32'h0150, sx(s_cmd));
      wr(ADR_MAX_SPEED, 32'h7fff);
      wr(ADR_MODE, 32'(MODE_S_T));
      wr(ADR_LIMIT_EN, 32'h1);
      for (int t = 0; t < 4; t++) begin
         set(1'b0, 1'b1, 1'b0, 1'b0, 3'h0, 2'h1, 2'(t));
         chk("trq_state", 32'(ST_TORQUE), 32'(mode));
         chk("trq_cmd", t == 0 ? sx(A_TRQ) : 32'(t * 17),
            sx(t_cmd));
         chk_bit("slim_on", 1'b1, s_act);
         chk("spd_lim", 32'h0100, sx(s_lim));
      end
      set(1'b0, 1'b0, 1'b0, 1'b0, 3'h0, 2'h1, 2'h3);
      chk("st_speed", 32'(ST_SPEED), 32'(mode));
      chk("st_spd_cmd", 32'h0100, sx(s_cmd));
      chk_bit("slim_spd", 1'b0, s_act);
      set(1'b0, 1'b1, 1'b0, 1'b0, 3'h0, 2'h1, 2'h3);
      chk("st_torque", 32'(ST_TORQUE), 32'(mode));
      wr(ADR_LIMIT_EN, 32'h0);
      step(3);
      chk_bit("slim_off", 1'b0, s_act);
      wr(ADR_MODE, 32'(MODE_PT_T));
      set(1'b0, 1'b0, 1'b1, 1'b0, 3'h0, 2'h0, 2'h2);
      chk("tp_pos", 32'(ST_POS_RUN), 32'(mode));
      rd(ADR_PULSE_CNT, cnt0);
      i_ctrl.send_pulses(5, 1'b0);
      step(3);
      rd(ADR_PULSE_CNT, rdv);
      chk("pulse_cnt", cnt0 + 32'h5, rdv);
      chk("pulse_pos", cnt0 + 32'h5, sx(p_cmd));
      i_ctrl.send_pulses(2, 1'b1);
      step(3);
      rd(ADR_PULSE_CNT, rdv);
      chk("pulse_down", cnt0 + 32'h3, rdv);
      set(1'b0, 1'b0, 1'b0, 1'b0, 3'h0, 2'h0, 2'h2);
      chk("tp_trq", 32'(ST_TORQUE), 32'(mode));
      chk("tp_trq_cmd", 32'h0022, sx(t_cmd));
      i_ctrl.send_pulses(5, 1'b0);
      step(3);
      rd(ADR_PULSE_CNT, rdv);
      chk("pulse_frozen", cnt0 + 32'h3, rdv);
      set(1'b0, 1'b0, 1'b1, 1'b0, 3'h0, 2'h0, 2'h2);
      chk("tp_back", 32'(ST_POS_RUN), 32'(mode));
      // A code outside the dual set parks the motor
      wr(ADR_MODE, 32'h05);
      step(3);
      chk("bad_idle", 32'(ST_IDLE), 32'(mode));
      chk_bit("bad_hold", 1'b1, hold);
      rd(ADR_STATUS, rdv);
      chk_bit("bad_flag", 1'b1, rdv[STAT_BAD_BIT]);
      report_and_stop();
   end
endmodule // testbench
